// ---- hdl/lane_code_error_status.sv ----
`timescale 1ns/1ps
`include "lane_err_defs.svh"

// Overview of operation
// - Disparity-error flags, lane n in bit n; lanes 2, 1, 0 among them.
// - Invalid-code register of eight flags, lane n in bit n.
// - Unexpected control-character register, one flag per lane, lane n in bit n.
// - Flag reads 1 once the lane's error count reaches the threshold.
// - Flag reads 0 while the lane's error count stays below threshold.
// - Status reads return the link chosen by the page register.

module lane_code_error_status
    import lane_err_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // APB slave
    input  wire logic [15:0]                 paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Decoder error strobes, one struct per link
    input  wire laneErr_s [`NUM_LINKS-1:0]   linkErr,
    // Interrupt
    output logic                             irq
);

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PAGE    = {2'b00, `IDX_LINK_PAGE, 2'b00};
    localparam logic [15:0] ADDR_DISP    = {2'b00, `IDX_DISP_STATUS, 2'b00};
    localparam logic [15:0] ADDR_INVALID = {2'b00, `IDX_INVALID_STATUS, 2'b00};
    localparam logic [15:0] ADDR_KCHAR   = {2'b00, `IDX_KCHAR_STATUS, 2'b00};
    localparam logic [15:0] ADDR_THR     = {2'b00, `IDX_THRESHOLD, 2'b00};
    localparam logic [15:0] ADDR_ISTAT   = {2'b00, `IDX_IRQ_STATUS, 2'b00};
    localparam logic [15:0] ADDR_IMASK   = {2'b00, `IDX_IRQ_MASK, 2'b00};
    localparam logic [15:0] ADDR_CTRL    = {2'b00, `IDX_COUNT_CTRL, 2'b00};

    top_s state_r;
    top_s state_nxt;

    logic [`NUM_LINKS-1:0][7:0] dispFlag;
    logic [`NUM_LINKS-1:0][7:0] invalidFlag;
    logic [`NUM_LINKS-1:0][7:0] kcharFlag;
    logic                       setupRd;
    logic                       accessWr;
    logic                       countClear;
    logic [2:0]                 anyFlag;
    logic [2:0]                 flagEvt;
    logic [7:0]                 selDisp;
    logic [7:0]                 selInvalid;
    logic [7:0]                 selKchar;

    // ------------------------------------------------------------
    // Per-lane counters
    // ------------------------------------------------------------
    for (genvar lk = 0; lk < `NUM_LINKS; lk++) begin : gLink
        for (genvar ln = 0; ln < `NUM_LANES; ln++) begin : gLane
            lane_err_counter uDisp (
                .clk       (clk),
                .rst       (rst),
                .incr      (linkErr[lk].disp[ln]),
                .clear     (countClear),
                .threshold (state_r.threshold),
                .flag      (dispFlag[lk][ln])
            );
            lane_err_counter uInvalid (
                .clk       (clk),
                .rst       (rst),
                .incr      (linkErr[lk].invalid[ln]),
                .clear     (countClear),
                .threshold (state_r.threshold),
                .flag      (invalidFlag[lk][ln])
            );
            lane_err_counter uKchar (
                .clk       (clk),
                .rst       (rst),
                .incr      (linkErr[lk].kchar[ln]),
                .clear     (countClear),
                .threshold (state_r.threshold),
                .flag      (kcharFlag[lk][ln])
            );
        end
    end

    // ------------------------------------------------------------
    // Paged status view
    // ------------------------------------------------------------
    assign selDisp    = dispFlag[state_r.linkSel];
    assign selInvalid = invalidFlag[state_r.linkSel];
    assign selKchar   = kcharFlag[state_r.linkSel];

    // Interrupt events watch all links, not only the paged one
    assign anyFlag[`EVT_DISP]    = |dispFlag;
    assign anyFlag[`EVT_INVALID] = |invalidFlag;
    assign anyFlag[`EVT_KCHAR]   = |kcharFlag;
    assign flagEvt               = anyFlag & ~state_r.flagSeen;

    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    assign setupRd    = psel && !penable && !pwrite;
    assign accessWr   = psel && penable && pwrite;
    assign countClear = accessWr && paddr == ADDR_CTRL && pwdata[`BIT_COUNT_CLEAR];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt          = state_r;
        state_nxt.flagSeen = anyFlag;

        // Read data and error are caught in setup so they come from flops
        if (psel && !penable) begin
            state_nxt.prdata  = 32'h0000_0000;
            state_nxt.pslverr = 1'b0;
            unique case (paddr)
                ADDR_PAGE: begin
                    state_nxt.prdata[`BIT_LINK_SEL] = state_r.linkSel;
                end
                ADDR_DISP: begin
                    state_nxt.prdata[7:0] = selDisp;
                end
                ADDR_INVALID: begin
                    state_nxt.prdata[7:0] = selInvalid;
                end
                ADDR_KCHAR: begin
                    state_nxt.prdata[7:0] = selKchar;
                end
                ADDR_THR: begin
                    state_nxt.prdata[7:0] = state_r.threshold;
                end
                ADDR_ISTAT: begin
                    state_nxt.prdata[2:0] = state_r.irqStat;
                end
                ADDR_IMASK: begin
                    state_nxt.prdata[2:0] = state_r.irqMask;
                end
                ADDR_CTRL: begin
                    state_nxt.prdata = 32'h0000_0000;
                end
                default: begin
                    state_nxt.pslverr = 1'b1;
                end
            endcase
            // Status registers are read only
            if (pwrite && (paddr == ADDR_DISP || paddr == ADDR_INVALID
                           || paddr == ADDR_KCHAR)) begin
                state_nxt.pslverr = 1'b1;
            end
        end

        // Sticky events; a new event beats a same-cycle clear
        state_nxt.irqStat = state_r.irqStat;
        if (accessWr && paddr == ADDR_ISTAT) begin
            state_nxt.irqStat = state_r.irqStat & ~pwdata[2:0];
        end
        state_nxt.irqStat = state_nxt.irqStat | flagEvt;

        if (accessWr) begin
            unique case (paddr)
                ADDR_PAGE: begin
                    state_nxt.linkSel = pwdata[`BIT_LINK_SEL];
                end
                ADDR_THR: begin
                    state_nxt.threshold = pwdata[7:0];
                end
                ADDR_IMASK: begin
                    state_nxt.irqMask = pwdata[2:0];
                end
                default: begin
                    state_nxt.linkSel = state_r.linkSel;
                end
            endcase
        end

        state_nxt.irq = |(state_nxt.irqStat & state_nxt.irqMask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r           <= '0;
            state_r.threshold <= `RST_THRESHOLD;
            state_r.irqMask   <= `RST_IRQ_MASK;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states: answer in the first access cycle
    assign pready  = 1'b1;
    assign prdata  = state_r.prdata;
    assign pslverr = state_r.pslverr && psel && penable;
    assign irq     = state_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    disp_read_a: assert property (@(posedge clk) disable iff (rst)
        setupRd && paddr == ADDR_DISP
        |=> prdata == {24'h000000, $past(selDisp)} && !pslverr)
        else $error("disparity status read mismatch");

    invalid_read_a: assert property (@(posedge clk) disable iff (rst)
        setupRd && paddr == ADDR_INVALID
        |=> prdata == {24'h000000, $past(selInvalid)})
        else $error("invalid-code status read mismatch");

    kchar_read_a: assert property (@(posedge clk) disable iff (rst)
        setupRd && paddr == ADDR_KCHAR
        |=> prdata == {24'h000000, $past(selKchar)})
        else $error("control-character status read mismatch");

    page_select_a: assert property (@(posedge clk) disable iff (rst)
        accessWr && paddr == ADDR_PAGE
        |=> state_r.linkSel == $past(pwdata[`BIT_LINK_SEL])
            && selDisp == dispFlag[$past(pwdata[`BIT_LINK_SEL])])
        else $error("page write not applied");

    thr_flag_a: assert property (@(posedge clk) disable iff (rst)
        accessWr && paddr == ADDR_THR && pwdata[7:0] == 8'h00
        |-> ##2 (&dispFlag) && (&invalidFlag) && (&kcharFlag))
        else $error("zero threshold did not raise all flags");

    event_sticky_a: assert property (@(posedge clk) disable iff (rst)
        state_r.irqStat[`EVT_DISP] && !(accessWr && paddr == ADDR_ISTAT)
        |=> state_r.irqStat[`EVT_DISP])
        else $error("sticky status bit lost");

    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        irq == |(state_r.irqStat & state_r.irqMask))
        else $error("interrupt level wrong");

    clear_zero_a: assert property (@(posedge clk) disable iff (rst)
        countClear && state_r.threshold != 8'h00 && $stable(state_r.threshold)
        |=> !(|dispFlag) && !(|invalidFlag) && !(|kcharFlag))
        else $error("flags stay high after counter clear");

    bad_addr_a: assert property (@(posedge clk) disable iff (rst)
        psel && !penable && paddr[1:0] != 2'b00 ##1 penable |-> pslverr)
        else $error("unmapped address not refused");

    ro_write_a: assert property (@(posedge clk) disable iff (rst)
        psel && !penable && pwrite && paddr == ADDR_DISP ##1 penable |-> pslverr)
        else $error("status write not refused");

    thr_write_a: assert property (@(posedge clk) disable iff (rst)
        accessWr && paddr == ADDR_THR
        |=> state_r.threshold == $past(pwdata[7:0]))
        else $error("threshold write not applied");

    // Set must win, so only a clear with no new event is checked here
    event_clear_a: assert property (@(posedge clk) disable iff (rst)
        accessWr && paddr == ADDR_ISTAT && !(|flagEvt)
        |=> (state_r.irqStat & $past(pwdata[2:0])) == 3'h0)
        else $error("status bit not cleared by write one");

    event_set_a: assert property (@(posedge clk) disable iff (rst)
        |flagEvt |=> (state_r.irqStat & $past(flagEvt)) == $past(flagEvt))
        else $error("flag rise did not set status bit");

endmodule : lane_code_error_status

// ---- hdl/lane_err_counter.sv ----
`timescale 1ns/1ps
`include "lane_err_defs.svh"

module lane_err_counter
    import lane_err_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Events and control
    input  wire logic       incr,
    input  wire logic       clear,
    input  wire logic [7:0] threshold,
    // Status
    output logic            flag
);

    cnt_s state_r;
    cnt_s state_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        if (clear) begin
            state_nxt.count = `RST_COUNT;
        end else if (incr && state_r.count != `COUNT_MAX) begin
            // Saturate so a high count never wraps below threshold
            state_nxt.count = state_r.count + 8'h01;
        end
        state_nxt.flag = (state_nxt.count >= threshold);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flag = state_r.flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flag_at_thr_a: assert property (@(posedge clk) disable iff (rst)
        (state_r.count >= threshold) && !clear |=> flag)
        else $error("flag low with count at threshold");

    flag_below_thr_a: assert property (@(posedge clk) disable iff (rst)
        $stable(threshold) && (state_r.count < threshold) |-> !flag)
        else $error("flag high with count below threshold");

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        incr && !clear && state_r.count != `COUNT_MAX
        |=> state_r.count == $past(state_r.count) + 8'h01)
        else $error("counter missed an error");

    reset_zero_a: assert property (@(posedge clk)
        rst |=> state_r.count == `RST_COUNT && !flag)
        else $error("counter not cleared by reset");

endmodule : lane_err_counter

// ---- shared/lane_err_defs.svh ----
`ifndef LANE_ERR_DEFS_SVH
`define LANE_ERR_DEFS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_LINK_PAGE       12'h300
`define IDX_DISP_STATUS     12'h46d
`define IDX_INVALID_STATUS  12'h46e
`define IDX_KCHAR_STATUS    12'h46f
`define IDX_THRESHOLD       12'h480
`define IDX_IRQ_STATUS      12'h481
`define IDX_IRQ_MASK        12'h482
`define IDX_COUNT_CTRL      12'h483

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_LINK_SEL        0
`define BIT_COUNT_CLEAR     0
`define EVT_DISP            0
`define EVT_INVALID         1
`define EVT_KCHAR           2

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define RST_THRESHOLD       8'h01
`define RST_IRQ_MASK        3'h0
`define RST_COUNT           8'h00
`define COUNT_MAX           8'hff
`define NUM_LINKS           2
`define NUM_LANES           8

`endif

// ---- shared/lane_err_pkg.sv ----
package lane_err_pkg;

    // Per-link error strobes from the 8b/10b decoders
    typedef struct packed {
        logic [7:0] disp;
        logic [7:0] invalid;
        logic [7:0] kchar;
    } laneErr_s;

    // APB request
    typedef struct packed {
        logic [15:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apbReq_s;

    // APB answer
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apbRsp_s;

    // Counter state
    typedef struct packed {
        logic [7:0] count;
        logic       flag;
    } cnt_s;

    // Top-level state
    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
        logic        linkSel;
        logic [7:0]  threshold;
        logic [2:0]  irqStat;
        logic [2:0]  irqMask;
        logic [2:0]  flagSeen;
        logic        irq;
    } top_s;

endpackage : lane_err_pkg

// ---- verification/lane_err_source.sv ----
`timescale 1ns/1ps
`include "lane_err_defs.svh"

module lane_err_source
    import lane_err_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Burst request
    input  wire logic                  go,
    input  wire logic                  link,
    input  wire logic [1:0]            errKind,
    input  wire logic [7:0]            lanes,
    input  wire logic [7:0]            num,
    // Burst status and error strobes
    output logic                       busy,
    output laneErr_s [`NUM_LINKS-1:0]  linkErr
);

    // ------------------------------------------------------------
    // Burst length
    // ------------------------------------------------------------
    logic [7:0] remain_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            remain_r <= 8'h00;
        end else if (go) begin
            remain_r <= num;
        end else if (remain_r != 8'h00) begin
            remain_r <= remain_r - 8'h01;
        end
    end

    assign busy = (remain_r != 8'h00);

    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    // Zero between bursts, so a stale lane never adds counts
    always_comb begin
        linkErr = '0;
        if (busy) begin
            case (errKind)
                2'h0: linkErr[link].disp = lanes;
                2'h1: linkErr[link].invalid = lanes;
                default: linkErr[link].kchar = lanes;
            endcase
        end
    end

endmodule : lane_err_source

// ---- verification/tb_lane_code_error_status.sv ----
`timescale 1ns/1ps
`include "lane_err_defs.svh"

module tb_lane_code_error_status;
    import lane_err_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic [15:0]               paddr = 16'h0000;
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [31:0]               pwdata = 32'h00000000;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    laneErr_s [`NUM_LINKS-1:0] linkErr;
    logic                      irq;
    logic                      go = 1'b0;
    logic                      link = 1'b0;
    logic [1:0]                errKind = 2'h0;
    logic [7:0]                lanes = 8'h00;
    logic [7:0]                num = 8'h00;
    logic                      busy;
    int                        n_fail = 0;
    int                        compares = 0;

    always #4 clk = ~clk;

    lane_code_error_status uut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .linkErr(linkErr), .irq(irq));

    lane_err_source src (.clk(clk), .rst(rst), .go(go), .link(link), .errKind(errKind),
        .lanes(lanes), .num(num), .busy(busy), .linkErr(linkErr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [1:0] lo,
                       input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, lo};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 100) begin
            n_fail++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 2'b00, 32'h00000000, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, expErr});
    endtask : rdChk

    task automatic wrChk(input logic [11:0] idx, input logic [31:0] wd, input logic expErr);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, 2'b00, wd, rd, err);
        chk({31'h0, err}, {31'h0, expErr});
    endtask : wrChk

    task automatic irqChk(input logic exp);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irqChk

    // Burst of n errors of one kind on the chosen lanes of one link
    task automatic inject(input logic lk, input logic [1:0] kd, input logic [7:0] ln,
                          input logic [7:0] n);
        int i;
        link <= lk;
        errKind <= kd;
        lanes <= ln;
        num <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            if (busy === 1'b0) break;
        end
        if (i == 300) begin
            n_fail++;
            results();
        end
    endtask : inject

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testReset;
        rdChk(`IDX_DISP_STATUS, 32'h0, 1'b0);
        rdChk(`IDX_INVALID_STATUS, 32'h0, 1'b0);
        rdChk(`IDX_KCHAR_STATUS, 32'h0, 1'b0);
        rdChk(`IDX_THRESHOLD, 32'h1, 1'b0);
        irqChk(1'b0);
        $display("test reset done");
    endtask : testReset

    // One count short, then lane 1 left short while lanes 2 and 0 reach it
    task automatic testThreshold;
        wrChk(`IDX_THRESHOLD, 32'h3, 1'b0);
        inject(1'b0, 2'h0, 8'h07, 8'h02);
        rdChk(`IDX_DISP_STATUS, 32'h0, 1'b0);
        inject(1'b0, 2'h0, 8'h05, 8'h01);
        rdChk(`IDX_DISP_STATUS, 32'h5, 1'b0);
        $display("test threshold done");
    endtask : testThreshold

    task automatic testTypes;
        inject(1'b0, 2'h1, 8'h81, 8'h03);
        rdChk(`IDX_INVALID_STATUS, 32'h81, 1'b0);
        inject(1'b0, 2'h2, 8'h88, 8'h03);
        rdChk(`IDX_KCHAR_STATUS, 32'h88, 1'b0);
        rdChk(`IDX_DISP_STATUS, 32'h5, 1'b0);
        $display("test types done");
    endtask : testTypes

    task automatic testPaging;
        wrChk(`IDX_LINK_PAGE, 32'h1, 1'b0);
        rdChk(`IDX_DISP_STATUS, 32'h0, 1'b0);
        inject(1'b1, 2'h0, 8'h20, 8'h03);
        rdChk(`IDX_DISP_STATUS, 32'h20, 1'b0);
        rdChk(`IDX_INVALID_STATUS, 32'h0, 1'b0);
        wrChk(`IDX_LINK_PAGE, 32'h0, 1'b0);
        rdChk(`IDX_DISP_STATUS, 32'h5, 1'b0);
        $display("test paging done");
    endtask : testPaging

    // Status registers are read-only; writes are refused and leave them alone
    task automatic testRefused;
        logic [31:0] rd;
        logic        err;
        wrChk(`IDX_DISP_STATUS, 32'hff, 1'b1);
        rdChk(`IDX_DISP_STATUS, 32'h5, 1'b0);
        rdChk(12'h7ff, 32'h0, 1'b1);
        // Misaligned byte address must be refused
        apb(1'b0, `IDX_THRESHOLD, 2'b10, 32'h00000000, rd, err);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test refused done");
    endtask : testRefused

    task automatic testIrq;
        rdChk(`IDX_IRQ_STATUS, 32'h7, 1'b0);
        irqChk(1'b0);
        wrChk(`IDX_IRQ_MASK, 32'h1, 1'b0);
        irqChk(1'b1);
        wrChk(`IDX_IRQ_STATUS, 32'h7, 1'b0);
        irqChk(1'b0);
        rdChk(`IDX_IRQ_STATUS, 32'h0, 1'b0);
        $display("test irq done");
    endtask : testIrq

    task automatic testClear;
        wrChk(`IDX_COUNT_CTRL, 32'h1, 1'b0);
        rdChk(`IDX_DISP_STATUS, 32'h0, 1'b0);
        rdChk(`IDX_KCHAR_STATUS, 32'h0, 1'b0);
        inject(1'b0, 2'h0, 8'h01, 8'h02);
        rdChk(`IDX_DISP_STATUS, 32'h0, 1'b0);
        // Zero threshold: every count meets it, so every flag reads 1
        wrChk(`IDX_THRESHOLD, 32'h0, 1'b0);
        rdChk(`IDX_DISP_STATUS, 32'hff, 1'b0);
        rdChk(`IDX_INVALID_STATUS, 32'hff, 1'b0);
        rdChk(`IDX_KCHAR_STATUS, 32'hff, 1'b0);
        irqChk(1'b1);
        wrChk(`IDX_THRESHOLD, 32'h3, 1'b0);
        rdChk(`IDX_DISP_STATUS, 32'h0, 1'b0);
        $display("test clear done");
    endtask : testClear

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        testReset();
        testThreshold();
        testTypes();
        testPaging();
        testRefused();
        testIrq();
        testClear();
        results();
    end

endmodule : tb_lane_code_error_status
